// *** hw/acc_conversion_control.v ***
// Conversion control and status logic with APB register access
//
// Overview of operation
// - Control write aborts and, unless off, restarts (software trigger) or re-arms (hardware trigger); when already armed it re-arms under either trigger
// - Compare off: every finish sets done flag
// - Compare on: done set only if compare true
// - Control write or low result read clears done
// - Done flag with enable raises interrupt
// - Single mode: one conversion per start
// - Continuous mode: back-to-back conversions after start
// - Input select sits in bits 4 to 0
// - Codes map channels, references, reserved, off
// - Off code powers down and isolates input
// - Off code stops continuous without extra conversion
// - Single mode returns to low power after finish
// - Trigger select picks software or hardware start
// - Compare direction: greater-equal or less-than
// - Active flag set on start, cleared on end
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "acc_defines.vh"
module acc_conversion_control #(
   parameter NCH  = 28,
   parameter RESW = 10
) (
   input  wire            clk,
   input  wire            rstn,
   input  wire            psel,
   input  wire            penable,
   input  wire            pwrite,
   input  wire [11:0]     paddr,
   input  wire [31:0]     pwdata,
   output reg  [31:0]     prdata,
   output wire            pready,
   output wire            pslverr,
   input  wire            hwConversionTrigger,
   output reg             convStart,
   output reg             convAbort,
   input  wire            convComplete,
   input  wire [RESW-1:0] convResult,
   output wire            converterPowerOn,
   output wire [NCH-1:0]  analogChannelSelect,
   output wire            highReferenceSelect,
   output wire            lowReferenceSelect,
   output wire            doneIrq,
   output wire            eventIrq
);
   localparam ST_IDLE  = 2'd0;
   localparam ST_ARMED = 2'd1;
   localparam ST_CONV  = 2'd2;

   reg  [1:0]      state_q;
   reg  [1:0]      state_d;
   reg             doneFlag_q;
   reg             irqEnable_q;
   reg             contEnable_q;
   reg  [4:0]      inputSelect_q;
   reg             trigSel_q;
   reg             cmpEnable_q;
   reg             cmpGreater_q;
   reg  [RESW-1:0] cmpValue_q;
   reg  [RESW-1:0] result_q;
   reg             trigPrev_q;
   reg  [2:0]      irqMask_q;
   wire            access;
   wire            wrSc1;
   wire            rdResL;
   wire            rdStat;
   wire            moduleOff;
   wire            trigRise;
   wire            compareTrue;
   wire            completeAccept;
   wire            latchResult;
   wire [2:0]      evStatus;
   reg  [2:0]      evPulse;
   reg             mapped;

   // Bus access decode; slave always answers in the access cycle
   assign access  = psel & penable;
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign wrSc1   = access & pwrite & (paddr == `ACC_OFF_SC1);
   assign rdResL  = access & ~pwrite & (paddr == `ACC_OFF_RESL);
   assign rdStat  = access & ~pwrite & (paddr == `ACC_OFF_IRQSTAT);

   // Input code decoding to the analog source enables
   acc_input_decode #(
      .NCH (NCH)
   ) u_decode (
      .inputSelect   (inputSelect_q),
      .channelEnable (analogChannelSelect),
      .highRefEnable (highReferenceSelect),
      .lowRefEnable  (lowReferenceSelect),
      .moduleOff     (moduleOff)
   );

   // Hardware trigger rising edge, ignored under software triggering
   assign trigRise = hwConversionTrigger & ~trigPrev_q & trigSel_q;

   // Compare condition in either direction
   assign compareTrue = cmpGreater_q ? (convResult >= cmpValue_q)
                                     : (convResult <  cmpValue_q);

   // A completion counts only while converting and not cut off by a write
   assign completeAccept = convComplete & (state_q == ST_CONV) & ~wrSc1;
   assign latchResult    = completeAccept & (~cmpEnable_q | compareTrue);

   // Conversion sequencer
   always @* begin
      state_d   = state_q;
      convStart = 1'b0;
      convAbort = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (wrSc1 && pwdata[4:0] != `ACC_SEL_OFF) begin
               if (trigSel_q) begin
                  state_d = ST_ARMED;
               end else begin
                  state_d   = ST_CONV;
                  convStart = 1'b1;
               end
            end
         end
         ST_ARMED: begin
            if (wrSc1) begin
               state_d = (pwdata[4:0] == `ACC_SEL_OFF) ? ST_IDLE : ST_ARMED;
            end else if (trigRise) begin
               state_d   = ST_CONV;
               convStart = 1'b1;
            end
         end
         ST_CONV: begin
            if (wrSc1) begin
               convAbort = 1'b1;
               if (pwdata[4:0] == `ACC_SEL_OFF) begin
                  state_d = ST_IDLE;
               end else if (trigSel_q) begin
                  state_d = ST_ARMED;
               end else begin
                  convStart = 1'b1;
               end
            end else if (convComplete) begin
               if (contEnable_q) begin
                  convStart = 1'b1;
               end else begin
                  state_d = trigSel_q ? ST_ARMED : ST_IDLE;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Converter powered only while a conversion runs
   assign converterPowerOn = (state_q == ST_CONV) & ~moduleOff;

   // State, edge history and result capture
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q    <= ST_IDLE;
         trigPrev_q <= 1'b0;
         result_q   <= {RESW{1'b0}};
      end else begin
         state_q    <= state_d;
         trigPrev_q <= hwConversionTrigger;
         if (latchResult) begin
            result_q <= convResult;
         end
      end
   end

   // Done flag: completion set wins over the read clear
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         doneFlag_q <= 1'b0;
      end else if (latchResult) begin
         doneFlag_q <= 1'b1;
      end else if (wrSc1 || rdResL) begin
         doneFlag_q <= 1'b0;
      end
   end

   assign doneIrq = doneFlag_q & irqEnable_q;

   // Software-writable control registers
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqEnable_q   <= |(`ACC_SC1_RESET & 8'h40); // Enable bit of the reset value
         contEnable_q  <= 1'b0;
         inputSelect_q <= `ACC_SEL_OFF;
         trigSel_q     <= 1'b0;
         cmpEnable_q   <= 1'b0;
         cmpGreater_q  <= 1'b0;
         cmpValue_q    <= {RESW{1'b0}};
         irqMask_q     <= 3'h0;
      end else if (access && pwrite) begin
         case (paddr)
            `ACC_OFF_SC1: begin
               irqEnable_q   <= pwdata[`ACC_SC1_IEN];
               contEnable_q  <= pwdata[`ACC_SC1_CONT];
               inputSelect_q <= pwdata[4:0];
            end
            `ACC_OFF_SC2: begin
               trigSel_q    <= pwdata[`ACC_SC2_TRIG];
               cmpEnable_q  <= pwdata[`ACC_SC2_CMPEN];
               cmpGreater_q <= pwdata[`ACC_SC2_CMPGT];
            end
            `ACC_OFF_CMPV: begin
               cmpValue_q <= pwdata[RESW-1:0];
            end
            `ACC_OFF_IRQMASK: begin
               irqMask_q <= pwdata[2:0];
            end
            default: begin
               irqMask_q <= irqMask_q;
            end
         endcase
      end
   end

   // Events for the sticky status register
   always @* begin
      evPulse = 3'h0;
      evPulse[`ACC_EV_DONE]     = latchResult;
      evPulse[`ACC_EV_ABORT]    = convAbort;
      evPulse[`ACC_EV_TRIGMISS] = trigRise & (state_q == ST_CONV);
   end

   acc_event_flags #(
      .N (3)
   ) u_events (
      .clk        (clk),
      .rstn       (rstn),
      .eventPulse (evPulse),
      .clearAll   (rdStat),
      .mask       (irqMask_q),
      .status     (evStatus),
      .irq        (eventIrq)
   );

   // Read data and address map
   always @* begin
      prdata = 32'h0;
      mapped = 1'b1;
      case (paddr)
         `ACC_OFF_SC1: begin
            prdata[7:0] = {doneFlag_q, irqEnable_q, contEnable_q, inputSelect_q};
         end
         `ACC_OFF_SC2: begin
            prdata[7:0] = {(state_q == ST_CONV), trigSel_q, cmpEnable_q,
                           cmpGreater_q, 4'h0};
         end
         `ACC_OFF_RESH: begin
            prdata[RESW-9:0] = result_q[RESW-1:8];
         end
         `ACC_OFF_RESL: begin
            prdata[7:0] = result_q[7:0];
         end
         `ACC_OFF_CMPV: begin
            prdata[RESW-1:0] = cmpValue_q;
         end
         `ACC_OFF_IRQSTAT: begin
            prdata[2:0] = evStatus;
         end
         `ACC_OFF_IRQMASK: begin
            prdata[2:0] = irqMask_q;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end
endmodule

// *** hw/acc_defines.vh ***
// Register map, field positions, reset values and codes of the conversion control block
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
`define ACC_OFF_SC1        12'h000
`define ACC_OFF_SC2        12'h004
`define ACC_OFF_RESH       12'h008
`define ACC_OFF_RESL       12'h00c
`define ACC_OFF_CMPV       12'h010
`define ACC_OFF_IRQSTAT    12'h014
`define ACC_OFF_IRQMASK    12'h018
`define ACC_SC1_DONE       7
`define ACC_SC1_IEN        6
`define ACC_SC1_CONT       5
`define ACC_SC2_ACTIVE     7
`define ACC_SC2_TRIG       6
`define ACC_SC2_CMPEN      5
`define ACC_SC2_CMPGT      4
`define ACC_SC1_RESET      8'h1f
`define ACC_SC2_RESET      8'h00
`define ACC_SEL_LASTCH     5'h1b
`define ACC_SEL_RSVD       5'h1c
`define ACC_SEL_HIGH_REFERENCE      5'h1d
`define ACC_SEL_LOW_REFERENCE      5'h1e
`define ACC_SEL_OFF        5'h1f
`define ACC_EV_DONE        0
`define ACC_EV_ABORT       1
`define ACC_EV_TRIGMISS    2
`endif

// *** hw/acc_input_decode.v ***
// Decoder from the input-select code to the analog source enables
`timescale 1ns/1ns
`include "acc_defines.vh"
module acc_input_decode #(
   parameter NCH = 28
) (
   input  wire [4:0]     inputSelect,
   output reg  [NCH-1:0] channelEnable,
   output reg            highRefEnable,
   output reg            lowRefEnable,
   output reg            moduleOff
);
   // Codes up to and including the last channel pick that channel; codes 1d and 1e pick the references
   always @* begin
      channelEnable = {NCH{1'b0}};
      highRefEnable = 1'b0;
      lowRefEnable  = 1'b0;
      moduleOff     = 1'b0;
      if (inputSelect <= `ACC_SEL_LASTCH) begin
         channelEnable[inputSelect] = 1'b1;
      end else if (inputSelect == `ACC_SEL_HIGH_REFERENCE) begin
         highRefEnable = 1'b1;
      end else if (inputSelect == `ACC_SEL_LOW_REFERENCE) begin
         lowRefEnable = 1'b1;
      end else if (inputSelect == `ACC_SEL_OFF) begin
         moduleOff = 1'b1;
      end
   end
endmodule

// *** hw/acc_event_flags.v ***
// Sticky event flags with clear-on-read and a mask onto one interrupt line
`timescale 1ns/1ns
module acc_event_flags #(
   parameter N = 3
) (
   input  wire         clk,
   input  wire         rstn,
   input  wire [N-1:0] eventPulse,
   input  wire         clearAll,
   input  wire [N-1:0] mask,
   output wire [N-1:0] status,
   output wire         irq
);
   reg [N-1:0] status_q;
   // A set in the clearing cycle wins over the clear
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_q <= {N{1'b0}};
      end else begin
         status_q <= (clearAll ? {N{1'b0}} : status_q) | eventPulse;
      end
   end
   assign status = status_q;
   assign irq    = |(status_q & mask);
endmodule

// *** dv/acc_checker.sv ***
// Port assertions for the conversion control block
`timescale 1ns/1ns
module acc_checker #(
   parameter NCH = 28
) (
   input wire           clk,
   input wire           rstn,
   input wire           psel,
   input wire           penable,
   input wire           pwrite,
   input wire [11:0]    paddr,
   input wire [31:0]    pwdata,
   input wire           convStart,
   input wire           convComplete,
   input wire           converterPowerOn,
   input wire [NCH-1:0] analogChannelSelect,
   input wire           highReferenceSelect,
   input wire           lowReferenceSelect,
   input wire           doneIrq
);
   wire           wr = psel && penable && pwrite;
   wire           sc1Wr = wr && paddr == 12'h000;
   wire           offWr = sc1Wr && pwdata[4:0] == 5'h1f;
   wire           fin = convComplete && !sc1Wr;
   reg  [4:0]     sel_q;
   reg            ien_q, cont_q, trig_q, cmpen_q;
   wire [NCH-1:0] hot = {{(NCH-1){1'b0}}, 1'b1} << sel_q;
   // Mirror of the written settings
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {ien_q, cont_q, sel_q} <= 7'h1f;
         {trig_q, cmpen_q} <= 2'h0;
      end else begin
         if (sc1Wr) {ien_q, cont_q, sel_q} <= pwdata[6:0];
         if (wr && paddr == 12'h004) {trig_q, cmpen_q} <= pwdata[6:5];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   start_on_write_a: assert property (sc1Wr && !offWr && !trig_q |-> convStart)
      else $error("no start");
   off_code_a: assert property (offWr |-> !convStart ##1 !converterPowerOn[*2])
      else $error("off code ran");
   write_clear_a: assert property (sc1Wr |=> !doneIrq)
      else $error("done kept");
   done_irq_a: assert property (fin && !cmpen_q && ien_q |=> doneIrq)
      else $error("no done irq");
   irq_gate_a: assert property (!ien_q |-> !doneIrq)
      else $error("irq ungated");
   decode_a: assert property (analogChannelSelect == (sel_q < 5'h1c ? hot : '0)
      && highReferenceSelect == (sel_q == 5'h1d) && lowReferenceSelect == (sel_q == 5'h1e))
      else $error("bad decode");
   single_idle_a: assert property (fin && !cont_q && !trig_q
      |-> !convStart ##1 !converterPowerOn) else $error("kept running");
   cont_run_a: assert property (fin && cont_q |-> convStart)
      else $error("no restart");
   soft_only_a: assert property (!trig_q && !sc1Wr && !convComplete |-> !convStart)
      else $error("stray start");
endmodule
bind acc_conversion_control acc_checker #(.NCH(NCH)) u_chk (.clk, .rstn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .convStart, .convComplete, .converterPowerOn,
   .analogChannelSelect, .highReferenceSelect, .lowReferenceSelect, .doneIrq);

// *** dv/acc_core_model.sv ***
// Behavioural converter core answering start and abort
`timescale 1ns/1ns
module acc_core_model (
   input  wire       clk,
   input  wire       rstn,
   input  wire       convStart,
   input  wire       convAbort,
   input  wire [3:0] latency,
   input  wire [9:0] nextResult,
   output reg        convComplete,
   output reg  [9:0] convResult
);
   reg [3:0] left_q;
   // Count down a conversion; the result is scrambled outside its valid cycle
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         left_q <= 4'h0;
         convComplete <= 1'b0;
         convResult <= 10'h0;
      end else begin
         convComplete <= left_q == 4'h1 && !convStart && !convAbort;
         convResult <= left_q == 4'h1 ? nextResult : ~convResult;
         if (convStart) left_q <= latency;
         else if (convAbort) left_q <= 4'h0;
         else if (left_q != 4'h0) left_q <= left_q - 4'h1;
      end
   end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the conversion control block
`timescale 1ns/1ns
module tb;
   logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic        hwConversionTrigger = 0, pready, pslverr, convStart, convAbort, convComplete;
   logic        converterPowerOn, highReferenceSelect, lowReferenceSelect, doneIrq, eventIrq;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [9:0]  nextResult = 10'h2a5, convResult;
   logic [3:0]  latency = 4'h3;
   logic [27:0] analogChannelSelect;
   int          err_total, checked;
   acc_conversion_control DUT (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .hwConversionTrigger, .convStart, .convAbort, .convComplete,
      .convResult, .converterPowerOn, .analogChannelSelect, .highReferenceSelect,
      .lowReferenceSelect, .doneIrq, .eventIrq);
   acc_core_model core (.clk, .rstn, .convStart, .convAbort, .latency, .nextResult,
      .convComplete, .convResult);
   // Bus clock
   always #50 clk = ~clk;
   // Cycle ceiling against a hang
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      close_out();
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Compare one result
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // One APB transfer; answer taken at the rising edge where pready is high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      @(negedge clk); // Let the completing edge settle before any compare
   endtask
   // Wait for the core to finish, then let that edge settle
   task automatic waitComp();
      do begin
         @(negedge clk);
      end while (convComplete !== 1'b1);
      @(negedge clk);
   endtask
   // Test sequence
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      apb(0, 12'h000, 0);
      chk(rd, 32'h1f, "reset value");
      apb(0, 12'h01c, 0);
      chk({err, rd[30:0]}, 32'h80000000, "unmapped");
      apb(1, 12'h018, 32'h1);
      apb(1, 12'h000, 32'h45);
      chk(32'(analogChannelSelect), 32'h20, "channel");
      waitComp();
      chk(32'({doneIrq, eventIrq, converterPowerOn}), 32'h6, "single");
      apb(0, 12'h014, 0);
      chk(rd, 32'h1, "status");
      apb(0, 12'h00c, 0);
      chk(rd, 32'ha5, "low result");
      apb(0, 12'h000, 0);
      chk(rd, 32'h45, "done cleared");
      $display("single test ended");
      latency <= 4'h9;
      apb(1, 12'h018, 0);
      apb(1, 12'h000, 32'h22);
      waitComp();
      apb(1, 12'h000, 32'h23);
      waitComp();
      chk(32'({converterPowerOn, analogChannelSelect}), 32'h10000008, "running");
      apb(0, 12'h004, 0);
      chk(32'(rd[7]), 1, "active");
      apb(1, 12'h000, 32'h3f);
      @(negedge clk);
      chk(32'({converterPowerOn, eventIrq}), 0, "stopped");
      apb(0, 12'h004, 0);
      chk(32'(rd[7]), 0, "inactive");
      apb(0, 12'h014, 0);
      chk(32'(rd[0]), 1, "masked event");
      $display("continuous test ended");
      apb(1, 12'h010, 32'h100);
      for (int i = 0; i < 4; i++) begin
         apb(1, 12'h004, i[1] ? 32'h30 : 32'h20);
         nextResult <= i[0] ? 10'h180 : 10'h050;
         hwConversionTrigger <= i[0] ^ i[1];
         apb(1, 12'h000, 32'h07);
         waitComp();
         apb(0, 12'h000, 0);
         chk(32'(rd[7]), 32'(i[0] == i[1]), "compare");
      end
      $display("compare test ended");
      apb(1, 12'h004, 32'h40);
      for (int c = 0; c < 32; c++) apb(1, 12'h000, 32'(c));
      apb(1, 12'h000, 32'h41);
      hwConversionTrigger <= 1'b1;
      waitComp();
      chk(32'(doneIrq), 1, "hw done");
      apb(0, 12'h00c, 0);
      repeat (20) @(posedge clk);
      hwConversionTrigger <= 1'b0;
      apb(0, 12'h000, 0);
      chk(rd, 32'h41, "one per trigger");
      $display("trigger test ended");
      close_out();
   end
endmodule
